// ==== hdl/bcl_pkg.sv ====
// Constants and types shared by the boot strap capture block.
package bcl_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int BCL_ADDR_W = 8;
  localparam logic [7:0] BCL_OFS_CAPTURE = 8'h14;
  localparam logic [7:0] BCL_OFS_STATUS = 8'h18;
  localparam logic [7:0] BCL_OFS_CONTROL = 8'h1C;

  // ****************************************************************
  // Field positions of the capture register
  // ****************************************************************
  localparam int BCL_POS_RSV_HI = 21;
  localparam int BCL_POS_ENDIAN = 20;
  localparam int BCL_POS_FAST = 19;
  localparam int BCL_POS_PCI = 17;
  localparam int BCL_POS_WIDTH = 16;
  localparam int BCL_POS_PLL = 12;
  localparam int BCL_POS_PINOUT = 8;
  localparam int BCL_POS_BOOT = 0;
  localparam logic [10:0] BCL_RSV_HI_VAL = 11'h001;

  // ****************************************************************
  // Status and control fields
  // ****************************************************************
  localparam int BCL_STAT_DONE = 0;
  localparam int BCL_STAT_PCI_DRIFT = 1;
  localparam int BCL_STAT_ANY_DRIFT = 2;
  localparam int BCL_CTRL_MON_EN = 0;
  localparam logic [31:0] BCL_CONTROL_RST = 32'h0000_0001;
  localparam logic [31:0] BCL_CAPTURE_RST = 32'h0000_0000;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int BCL_CLK_PERIOD_PS = 10000;
  localparam int BCL_SETTLE_NS = 20;
  localparam int BCL_SETTLE_CYC =
    (BCL_SETTLE_NS * 1000 + BCL_CLK_PERIOD_PS - 1) / BCL_CLK_PERIOD_PS;
  localparam logic [3:0] BCL_SETTLE_LAST = 4'(BCL_SETTLE_CYC - 1);

  // ****************************************************************
  // Bus responses
  // ****************************************************************
  localparam logic [1:0] BCL_RESP_OKAY = 2'h0;
  localparam logic [1:0] BCL_RESP_DECERR = 2'h3;

  // ****************************************************************
  // Types
  // ****************************************************************
  localparam int BCL_STRAP_W = 14;

  typedef struct packed {
    logic little_endian_sel;
    logic fast_boot;
    logic pci_enable_default;
    logic chip_select_two_wide;
    logic [2:0] pll_mult_select;
    logic [2:0] pinout_mode_default;
    logic [3:0] boot_mode;
  } bcl_strap_t;

  typedef enum logic [2:0] {
    BCL_ST_HOLD = 3'b001,
    BCL_ST_SETTLE = 3'b010,
    BCL_ST_LOCKED = 3'b100
  } bcl_state_t;

  typedef enum logic [1:0] {
    BCL_SEL_NONE,
    BCL_SEL_CAPTURE,
    BCL_SEL_STATUS,
    BCL_SEL_CONTROL
  } bcl_sel_t;

endpackage : bcl_pkg

// ==== hdl/bcl_sync.sv ====
// Two-stage synchroniser for the strap pin bundle.
`timescale 1ns/100ps
`default_nettype none
module bcl_sync #(
  parameter int WIDTH = 14
) (
  input wire logic ref_clk_i,           // System clock.
  input wire logic [WIDTH-1:0] async_i, // Pin levels.
  output logic [WIDTH-1:0] sync_o       // Levels in the clock domain.
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // The stages carry data only, so they run through reset and hold
  // valid pin levels at the moment reset is released.
  always_ff @(posedge ref_clk_i) begin
    meta_q <= async_i;
    sync_q <= meta_q;
  end

  assign sync_o = sync_q;

endmodule : bcl_sync
`default_nettype wire

// ==== hdl/bcl_drift_mon.sv ====
// Sticky monitor that flags a pin moving away from its captured level.
`timescale 1ns/100ps
`default_nettype none
module bcl_drift_mon #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk_i,           // System clock.
  input wire logic reset_i,             // Synchronous reset.
  input wire logic enable_i,            // Monitor armed.
  input wire logic [WIDTH-1:0] live_i,  // Synchronised pin levels.
  input wire logic [WIDTH-1:0] held_i,  // Captured levels.
  input wire logic clear_i,             // Clear pulse from software.
  output logic flag_o                   // Sticky drift flag.
);

  logic flag_q;
  logic set_w;

  assign set_w = enable_i && (live_i != held_i);

  // A new mismatch in the clearing cycle keeps the flag set.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      flag_q <= 1'b0;
    end else if (set_w) begin
      flag_q <= 1'b1;
    end else if (clear_i) begin
      flag_q <= 1'b0;
    end
  end

  assign flag_o = flag_q;

endmodule : bcl_drift_mon
`default_nettype wire

// ==== hdl/bcl_boot_config_latch.sv ====
// Boot strap capture register with its AXI4-Lite slave.
// Contract
// (RULE1) Bit 19 holds the fast boot flag.
// (RULE2) Fast boot flag comes from its captured pin.
// (RULE3) Reserved bits ignore writes, nothing changes.
// (RULE4) Bit 17 holds PCI enable default.
// (RULE5) PCI default drives pin pulls, not PCI.
// (RULE6) Board holds PCI enable pin constant always; the bench board model holds it only outside reset.
// (RULE7) Bit 16 selects chip select two width.
// (RULE8) Width bit loads async width field default.
// (RULE9) Bits 14:12 multiplier, applied only in fast boot.
// (RULE10) Bits 10:8 pinout mode, sets pin select default.
// (RULE11) Bits 3:0 hold the boot mode select.
// (RULE12) Fields read-only, captured at reset release.
// (RULE13) Bit 20 holds the little endian selection.
// (RULE14) Captured values stay until the next reset.
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
module bcl_boot_config_latch (
  input wire logic ref_clk_i,                  // System clock.
  input wire logic reset_i,                    // Synchronous reset.
  input wire bcl_pkg::bcl_strap_t strap_pins_i, // Strap pin levels.
  // AXI4-Lite write address channel.
  input wire logic [bcl_pkg::BCL_ADDR_W-1:0] s_axil_awaddr_i, // Address.
  input wire logic [2:0] s_axil_awprot_i,      // Protection, unused.
  input wire logic s_axil_awvalid_i,           // Address valid.
  output logic s_axil_awready_o,               // Address ready.
  // AXI4-Lite write data channel.
  input wire logic [31:0] s_axil_wdata_i,      // Write data.
  input wire logic [3:0] s_axil_wstrb_i,       // Byte strobes.
  input wire logic s_axil_wvalid_i,            // Data valid.
  output logic s_axil_wready_o,                // Data ready.
  // AXI4-Lite write response channel.
  output logic [1:0] s_axil_bresp_o,           // Write response.
  output logic s_axil_bvalid_o,                // Response valid.
  input wire logic s_axil_bready_i,            // Response ready.
  // AXI4-Lite read address channel.
  input wire logic [bcl_pkg::BCL_ADDR_W-1:0] s_axil_araddr_i, // Address.
  input wire logic [2:0] s_axil_arprot_i,      // Protection, unused.
  input wire logic s_axil_arvalid_i,           // Address valid.
  output logic s_axil_arready_o,               // Address ready.
  // AXI4-Lite read data channel.
  output logic [31:0] s_axil_rdata_o,          // Read data.
  output logic [1:0] s_axil_rresp_o,           // Read response.
  output logic s_axil_rvalid_o,                // Read valid.
  input wire logic s_axil_rready_i,            // Read ready.
  // Captured defaults and status flags towards the rest of the device.
  output logic little_endian_sel_o,            // 1 little, 0 big endian.
  output logic fast_boot_o,                    // Fast boot flag.
  output logic pci_enable_default_o,           // Default of pci_pin_enable.
  output logic pci_pull_enable_o,              // PCI pin pull resistors on.
  output logic async_width_field_o,            // 1 16-bit, 0 8-bit.
  output logic [2:0] pll_mult_select_o,        // Captured multiplier.
  output logic pll_mult_apply_o,               // Multiplier in force.
  output logic [2:0] pinout_mode_default_o,    // Default async pinout.
  output logic [3:0] boot_mode_o,              // Boot mode select.
  output logic capture_done_o,                 // Capture has completed.
  output logic pci_drift_o                     // PCI enable pin moved.
);

  import bcl_pkg::*;

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Maps a word address onto the register it selects.
  function automatic bcl_sel_t bcl_decode(
    input logic [BCL_ADDR_W-1:0] addr
  );
    logic [7:0] word;
    word = {addr[7:2], 2'b00};
    if (word == BCL_OFS_CAPTURE) begin
      bcl_decode = BCL_SEL_CAPTURE;
    end else if (word == BCL_OFS_STATUS) begin
      bcl_decode = BCL_SEL_STATUS;
    end else if (word == BCL_OFS_CONTROL) begin
      bcl_decode = BCL_SEL_CONTROL;
    end else begin
      bcl_decode = BCL_SEL_NONE;
    end
  endfunction : bcl_decode
  // Places the captured fields at their bit positions.
  function automatic logic [31:0] bcl_pack(input bcl_strap_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[31:BCL_POS_RSV_HI] = BCL_RSV_HI_VAL;
    w[BCL_POS_ENDIAN] = s.little_endian_sel;                 // RULE13
    w[BCL_POS_FAST] = s.fast_boot;                           // RULE1
    w[BCL_POS_PCI] = s.pci_enable_default;                   // RULE4
    w[BCL_POS_WIDTH] = s.chip_select_two_wide;               // RULE7
    w[BCL_POS_PLL+2:BCL_POS_PLL] = s.pll_mult_select;        // RULE9
    w[BCL_POS_PINOUT+2:BCL_POS_PINOUT] = s.pinout_mode_default; // RULE10
    w[BCL_POS_BOOT+3:BCL_POS_BOOT] = s.boot_mode;            // RULE11
    bcl_pack = w;
  endfunction : bcl_pack
  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [BCL_STRAP_W-1:0] pins_sync_w;
  bcl_strap_t pins_live_w;
  bcl_strap_t capture_q;
  bcl_state_t state_q;
  logic [3:0] settle_cnt_q;
  logic capture_w;
  logic pll_apply_q;
  logic [31:0] control_q;
  logic pci_drift_w;
  logic any_drift_w;
  logic monitor_en_w;
  logic clr_pci_drift_w;
  logic clr_any_drift_w;
  logic awready_q;
  logic aw_full_q;
  logic [BCL_ADDR_W-1:0] awaddr_q;
  logic wready_q;
  logic w_full_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic do_write_w;
  bcl_sel_t wsel_w;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic ar_take_w;
  bcl_sel_t rsel_w;
  logic [31:0] status_w;

  // ****************************************************************
  // Strap pin synchroniser
  // ****************************************************************
  bcl_sync #(
    .WIDTH(BCL_STRAP_W)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .async_i(strap_pins_i),
    .sync_o(pins_sync_w)
  );
  assign pins_live_w = bcl_strap_t'(pins_sync_w);

  // ****************************************************************
  // Capture sequence
  // ****************************************************************
  // The pins are taken once, a short settle after reset release, and
  // the sequence then rests in the locked state until the next reset.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_q <= BCL_ST_HOLD;
    end else begin
      case (state_q)
        BCL_ST_HOLD: begin
          state_q <= BCL_ST_SETTLE;
        end
        BCL_ST_SETTLE: begin
          if (settle_cnt_q == BCL_SETTLE_LAST) begin
            state_q <= BCL_ST_LOCKED;
          end
        end
        BCL_ST_LOCKED: begin
          state_q <= BCL_ST_LOCKED;                          // RULE14
        end
        default: begin
          state_q <= BCL_ST_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      settle_cnt_q <= 4'h0;
    end else if (state_q == BCL_ST_SETTLE) begin
      settle_cnt_q <= settle_cnt_q + 4'h1;
    end else begin
      settle_cnt_q <= 4'h0;
    end
  end
  assign capture_w = (state_q == BCL_ST_SETTLE) &&
                     (settle_cnt_q == BCL_SETTLE_LAST);
  // Only the capture strobe loads these fields; no bus write reaches
  // them and later pin movement is not followed.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      capture_q <= bcl_strap_t'(BCL_CAPTURE_RST[BCL_STRAP_W-1:0]);
    end else if (capture_w) begin
      capture_q <= pins_live_w;                  // RULE2 RULE12 RULE14
    end
  end
  // The multiplier select is in force only under fast boot.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pll_apply_q <= 1'b0;
    end else if (capture_w) begin
      pll_apply_q <= pins_live_w.fast_boot;                  // RULE9
    end
  end

  // ****************************************************************
  // Pin drift monitors
  // ****************************************************************
  assign monitor_en_w = (state_q == BCL_ST_LOCKED) &&
                        control_q[BCL_CTRL_MON_EN];
  // The PCI enable pin must not move while the device runs.
  bcl_drift_mon #(
    .WIDTH(1)
  ) u_pci_mon (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .enable_i(monitor_en_w),
    .live_i(pins_live_w.pci_enable_default),                 // RULE6
    .held_i(capture_q.pci_enable_default),
    .clear_i(clr_pci_drift_w),
    .flag_o(pci_drift_w)
  );

  bcl_drift_mon #(
    .WIDTH(BCL_STRAP_W)
  ) u_any_mon (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .enable_i(monitor_en_w),
    .live_i(pins_live_w),
    .held_i(capture_q),
    .clear_i(clr_any_drift_w),
    .flag_o(any_drift_w)
  );

  // ****************************************************************
  // AXI4-Lite write path
  // ****************************************************************
  assign do_write_w = aw_full_q && w_full_q && !bvalid_q;
  assign wsel_w = bcl_decode(awaddr_q);
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      awready_q <= 1'b0;
      aw_full_q <= 1'b0;
      awaddr_q <= '0;
    end else if (s_axil_awvalid_i && awready_q) begin
      awready_q <= 1'b0;
      aw_full_q <= 1'b1;
      awaddr_q <= s_axil_awaddr_i;
    end else if (do_write_w) begin
      aw_full_q <= 1'b0;
    end else if (!aw_full_q && !bvalid_q) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      wready_q <= 1'b0;
      w_full_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_axil_wvalid_i && wready_q) begin
      wready_q <= 1'b0;
      w_full_q <= 1'b1;
      wdata_q <= s_axil_wdata_i;
      wstrb_q <= s_axil_wstrb_i;
    end else if (do_write_w) begin
      w_full_q <= 1'b0;
    end else if (!w_full_q && !bvalid_q) begin
      wready_q <= 1'b1;
    end
  end

  // The capture register answers OKAY to a write but keeps its value.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      bvalid_q <= 1'b0;
      bresp_q <= BCL_RESP_OKAY;
    end else if (do_write_w) begin
      bvalid_q <= 1'b1;
      if (wsel_w == BCL_SEL_NONE) begin
        bresp_q <= BCL_RESP_DECERR;
      end else begin
        bresp_q <= BCL_RESP_OKAY;                            // RULE3
      end
    end else if (bvalid_q && s_axil_bready_i) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      control_q <= BCL_CONTROL_RST;
    end else if (do_write_w && (wsel_w == BCL_SEL_CONTROL) &&
                 wstrb_q[0]) begin
      control_q[BCL_CTRL_MON_EN] <= wdata_q[BCL_CTRL_MON_EN];
    end
  end
  // Status drift flags clear by writing one to them.
  assign clr_pci_drift_w = do_write_w && (wsel_w == BCL_SEL_STATUS) &&
                           wstrb_q[0] && wdata_q[BCL_STAT_PCI_DRIFT];
  assign clr_any_drift_w = do_write_w && (wsel_w == BCL_SEL_STATUS) &&
                           wstrb_q[0] && wdata_q[BCL_STAT_ANY_DRIFT];
  // ****************************************************************
  // AXI4-Lite read path
  // ****************************************************************
  assign ar_take_w = s_axil_arvalid_i && arready_q;
  assign rsel_w = bcl_decode(s_axil_araddr_i);
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[BCL_STAT_DONE] = (state_q == BCL_ST_LOCKED);
    status_w[BCL_STAT_PCI_DRIFT] = pci_drift_w;
    status_w[BCL_STAT_ANY_DRIFT] = any_drift_w;
  end
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      arready_q <= 1'b0;
    end else if (ar_take_w) begin
      arready_q <= 1'b0;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= BCL_RESP_OKAY;
    end else if (ar_take_w) begin
      rvalid_q <= 1'b1;
      rresp_q <= BCL_RESP_OKAY;
      if (rsel_w == BCL_SEL_CAPTURE) begin
        rdata_q <= bcl_pack(capture_q);                      // RULE12
      end else if (rsel_w == BCL_SEL_STATUS) begin
        rdata_q <= status_w;
      end else if (rsel_w == BCL_SEL_CONTROL) begin
        rdata_q <= control_q;
      end else begin
        rdata_q <= 32'h0000_0000;
        rresp_q <= BCL_RESP_DECERR;
      end
    end else if (rvalid_q && s_axil_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axil_awready_o = awready_q;
  assign s_axil_wready_o = wready_q;
  assign s_axil_bvalid_o = bvalid_q;
  assign s_axil_bresp_o = bresp_q;
  assign s_axil_arready_o = arready_q;
  assign s_axil_rvalid_o = rvalid_q;
  assign s_axil_rdata_o = rdata_q;
  assign s_axil_rresp_o = rresp_q;
  assign little_endian_sel_o = capture_q.little_endian_sel;    // RULE13
  assign fast_boot_o = capture_q.fast_boot;                    // RULE1
  assign pci_enable_default_o = capture_q.pci_enable_default;  // RULE4
  // The pulls follow the default; no PCI controller state is touched.
  assign pci_pull_enable_o = capture_q.pci_enable_default;     // RULE5
  // Only the async width default; pin selection is left alone.
  assign async_width_field_o = capture_q.chip_select_two_wide; // RULE8
  assign pll_mult_select_o = capture_q.pll_mult_select;        // RULE9
  assign pll_mult_apply_o = pll_apply_q;                       // RULE9
  // Only the pin select default; async interface setup is left alone.
  assign pinout_mode_default_o = capture_q.pinout_mode_default; // RULE10
  assign boot_mode_o = capture_q.boot_mode;                    // RULE11
  assign capture_done_o = state_q[2];
  assign pci_drift_o = pci_drift_w;

endmodule : bcl_boot_config_latch
`default_nettype wire

// ==== tb/bcl_strap_model.sv ====
// Board model that drives the strap pins of the capture block.
`timescale 1ns/100ps
`default_nettype none
module bcl_strap_model (
  input wire logic ref_clk_i,            // System clock.
  input wire logic reset_i,              // Device reset.
  input wire bcl_pkg::bcl_strap_t board_i, // Levels set by the board.
  output bcl_pkg::bcl_strap_t pins_o     // Levels seen at the pins.
);
  import bcl_pkg::*;
  // Outside reset the PCI enable strap is never moved by the board.
  always @(posedge ref_clk_i) begin
    pins_o <= board_i;
    if (!reset_i) begin
      pins_o.pci_enable_default <= pins_o.pci_enable_default;
    end
  end
endmodule : bcl_strap_model
`default_nettype wire

// ==== tb/bcl_boot_config_latch_checker.sv ====
// Assertions on the ports of the boot strap capture block.
`timescale 1ns/100ps
`default_nettype none
module bcl_boot_config_latch_checker (
  input wire logic ref_clk_i,            // System clock.
  input wire logic reset_i,              // Synchronous reset.
  input wire logic s_axil_awvalid_i,     // Address valid.
  input wire logic s_axil_awready_o,     // Address ready.
  input wire logic s_axil_wvalid_i,      // Data valid.
  input wire logic s_axil_wready_o,      // Data ready.
  input wire logic s_axil_bvalid_o,      // Response valid.
  input wire logic s_axil_bready_i,      // Response ready.
  input wire logic s_axil_arvalid_i,     // Read address valid.
  input wire logic s_axil_arready_o,     // Read address ready.
  input wire logic s_axil_rvalid_o,      // Read valid.
  input wire logic fast_boot_o,          // Fast boot flag.
  input wire logic pci_enable_default_o, // PCI default.
  input wire logic pci_pull_enable_o,    // PCI pulls.
  input wire logic [2:0] pll_mult_select_o, // Multiplier.
  input wire logic pll_mult_apply_o,     // Multiplier in force.
  input wire logic [3:0] boot_mode_o,    // Boot mode.
  input wire logic capture_done_o        // Capture done.
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  a_pull_follow: assert property (
    pci_pull_enable_o == pci_enable_default_o) else $error("pull mismatch");
  a_apply_fast: assert property (
    pll_mult_apply_o == fast_boot_o) else $error("apply mismatch");
  a_done_sticky: assert property (
    capture_done_o |=> capture_done_o) else $error("done dropped");
  a_fields_stable: assert property (
    capture_done_o |=> $stable({fast_boot_o, boot_mode_o, pll_mult_select_o}))
    else $error("captured field moved");
  a_capture_time: assert property (
    $fell(reset_i) |-> !capture_done_o [*3] ##1 capture_done_o)
    else $error("capture not at third edge");
  a_read_answer: assert property (
    s_axil_arvalid_i && s_axil_arready_o |=> s_axil_rvalid_o)
    else $error("late read answer");
  a_write_answer: assert property (
    s_axil_awvalid_i && s_axil_awready_o && s_axil_wvalid_i && s_axil_wready_o
    |=> ##1 s_axil_bvalid_o) else $error("late write answer");
  a_resp_once: assert property (
    s_axil_bvalid_o && s_axil_bready_i |=> !s_axil_bvalid_o)
    else $error("response repeated");
endmodule : bcl_boot_config_latch_checker
bind bcl_boot_config_latch bcl_boot_config_latch_checker u_chk (.ref_clk_i,
  .reset_i, .s_axil_awvalid_i, .s_axil_awready_o, .s_axil_wvalid_i,
  .s_axil_wready_o, .s_axil_bvalid_o, .s_axil_bready_i, .s_axil_arvalid_i,
  .s_axil_arready_o, .s_axil_rvalid_o, .fast_boot_o, .pci_enable_default_o,
  .pci_pull_enable_o, .pll_mult_select_o, .pll_mult_apply_o, .boot_mode_o,
  .capture_done_o);
`default_nettype wire

// ==== tb/bcl_boot_config_latch_tb.sv ====
// Self-checking bench for the boot strap capture block.
`timescale 1ns/100ps
`default_nettype none
module bcl_boot_config_latch_tb;
  import bcl_pkg::*;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  bcl_strap_t board = '0;
  bcl_strap_t pins;
  logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
  logic [31:0] w_d = 32'h0, rdata;
  logic [3:0] w_s = 4'h0;
  logic awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
  logic awr, wr, bv, arr, rv, le, fb, pci, pull, wid, app, done, drift;
  logic [1:0] bresp, rresp;
  logic [2:0] pll, pin;
  logic [3:0] boot;
  int err_total = 0, tests_run = 0, seed = 32'h6a9e;
  bcl_strap_model board_m (.ref_clk_i, .reset_i, .board_i(board),
    .pins_o(pins));
  bcl_boot_config_latch dut (.ref_clk_i, .reset_i, .strap_pins_i(pins),
    .s_axil_awaddr_i(aw_a), .s_axil_awprot_i(3'h0), .s_axil_awvalid_i(awv),
    .s_axil_awready_o(awr), .s_axil_wdata_i(w_d), .s_axil_wstrb_i(w_s),
    .s_axil_wvalid_i(wv), .s_axil_wready_o(wr), .s_axil_bresp_o(bresp),
    .s_axil_bvalid_o(bv), .s_axil_bready_i(brd), .s_axil_araddr_i(ar_a),
    .s_axil_arprot_i(3'h0), .s_axil_arvalid_i(arv), .s_axil_arready_o(arr),
    .s_axil_rdata_o(rdata), .s_axil_rresp_o(rresp), .s_axil_rvalid_o(rv),
    .s_axil_rready_i(rrd), .little_endian_sel_o(le), .fast_boot_o(fb),
    .pci_enable_default_o(pci), .pci_pull_enable_o(pull),
    .async_width_field_o(wid), .pll_mult_select_o(pll), .pll_mult_apply_o(app),
    .pinout_mode_default_o(pin), .boot_mode_o(boot), .capture_done_o(done),
    .pci_drift_o(drift));
  initial forever #5 ref_clk_i = ~ref_clk_i;
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    aw_a <= a;
    w_d <= d;
    w_s <= 4'hF;
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!(bv && !awv && !wv) && n < 50);
    r = bresp;
    brd <= 1'b0;
    @(posedge ref_clk_i);
    if (n >= 50) err_total++;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    ar_a <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (arr) arv <= 1'b0;
    end while (!(rv && !arv) && n < 50);
    d = rdata;
    r = rresp;
    rrd <= 1'b0;
    @(posedge ref_clk_i);
    if (n >= 50) err_total++;
  endtask : axi_rd
  // Register image built from the strap levels, upper bits read 11'h001.
  function automatic logic [31:0] exp_reg(input bcl_strap_t s);
    int v;
    v = 'h200000 + int'(s.little_endian_sel) * 2**20;
    v += int'(s.fast_boot) * 2**19 + int'(s.pci_enable_default) * 2**17;
    v += int'(s.chip_select_two_wide) * 2**16;
    v += int'(s.pll_mult_select) * 2**12 + int'(s.pinout_mode_default) * 2**8;
    return 32'(v + int'(s.boot_mode));
  endfunction : exp_reg
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_total++;
    stop_test();
  end
  initial begin
    bcl_strap_t s;
    logic [31:0] d, e, x;
    logic [1:0] r;
    for (int i = 0; i < 4; i++) begin
      s = bcl_strap_t'($random(seed));
      s.fast_boot = i[0];
      s.chip_select_two_wide = i[1];
      board <= s;
      reset_i <= 1'b1;
      repeat (5) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      repeat (6) @(posedge ref_clk_i);
      e = exp_reg(s);
      axi_rd(BCL_OFS_CAPTURE, d, r);
      check("capture", d, e);
      check("read resp", 32'(r), 32'(BCL_RESP_OKAY));
      x = 32'({s[13:11], s[11], s[10:7], s.fast_boot, s[6:0], 1'b1});
      d = 32'({le, fb, pci, pull, wid, pll, app, pin, boot, done});
      check("defaults", d, x);
      board <= ~s;
      axi_wr(BCL_OFS_CAPTURE, 32'hFFFF_FFFF, r);
      check("write resp", 32'(r), 32'(BCL_RESP_OKAY));
      repeat (6) @(posedge ref_clk_i);
      axi_rd(BCL_OFS_CAPTURE, d, r);
      check("capture held", d, e);
      axi_rd(BCL_OFS_STATUS, d, r);
      check("status", d, 32'h0000_0005);
      check("pci drift", 32'(drift), 32'h0000_0000);
      axi_wr(BCL_OFS_CONTROL, 32'h0000_0000, r);
      axi_wr(BCL_OFS_STATUS, 32'h0000_0006, r);
      axi_rd(BCL_OFS_STATUS, d, r);
      check("status cleared", d, 32'h0000_0001);
      axi_rd(8'h40, d, r);
      check("unmapped", {d[29:0], r}, 32'(BCL_RESP_DECERR));
      $display("test %0d done", i);
    end
    stop_test();
  end
endmodule : bcl_boot_config_latch_tb
`default_nettype wire
